/* File: shared/hdms_params.svh */
/*
 * Constants of the vibration source selector: register offsets, control
 * field positions, mode codes, reset values and the duty meter window.
 * Assumes it is included by its bare name; the guard allows several includes.
 */
`ifndef HDMS_PARAMS_SVH
`define HDMS_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define HDMS_OFS_CONTROL      8'h09
`define HDMS_OFS_LIVE_AMP     8'h0A
`define HDMS_OFS_RAM_ADDR     8'h0B

// ****************************************
// Control and live amplitude register fields
// ****************************************
`define HDMS_BIT_TRIGGER      7
`define HDMS_BIT_RAM_EN       6
`define HDMS_BIT_CLK_GATE     5
`define HDMS_MODE_MSB         4
`define HDMS_SIGN_BIT         7

// ****************************************
// Mode codes
// ****************************************
`define HDMS_MODE_IDLE        5'h00
`define HDMS_MODE_PWM0        5'h01
`define HDMS_MODE_PWM4        5'h05
`define HDMS_MODE_LIVE_REG    5'h06
`define HDMS_MODE_STORED0     5'h07
`define HDMS_MODE_STORED4     5'h0B
`define HDMS_MODE_STORED_REG  5'h0C
`define HDMS_MODE_RAM_FIRST   5'h0D
`define HDMS_MODE_RAM_PIN4    5'h10
`define HDMS_MODE_RAM_PIN0    5'h11
`define HDMS_MODE_RAM_REG     5'h12
`define HDMS_RAM_PIN_BASE     5'h0C

// ****************************************
// Reset values and meter window
// ****************************************
`define HDMS_RST_REG          8'h00
`define HDMS_WIN_BITS         8

`endif

/* File: shared/hdms_pkg.sv */
/*
 * Types of the vibration source selector: state codes, source kinds and
 * the packed state record. Assumes the constants header is on the path.
 */
package hdms_pkg;
`include "hdms_params.svh"

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_LIVE  = 4'h2,
        ST_ARMED = 4'h4,
        ST_PLAY  = 4'h8
    } hdms_state_t;

    typedef enum logic [2:0]
    {
        K_IDLE       = 3'h0,
        K_PWM        = 3'h1,
        K_REG        = 3'h2,
        K_STORED_PIN = 3'h3,
        K_STORED_REG = 3'h4,
        K_RAM_PIN    = 3'h5,
        K_RAM_REG    = 3'h6
    } hdms_kind_t;

    typedef struct packed
    {
        hdms_state_t state;
        logic        trig;
        logic        ram_en;
        logic        gate;
        logic [4:0]  mode;
        logic [7:0]  live_amp;
        logic [7:0]  ram_addr;
        logic [7:0]  rdata;
        logic [4:0]  pins_prev;
        logic [6:0]  level;
        logic        neg;
        logic        en;
        logic        stored_start;
        logic        ram_start;
        logic [7:0]  play_addr;
    } hdms_st_t;
endpackage

/* File: shared/hdms_meter_if.sv */
/*
 * Link between the selector and its duty cycle meter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface hdms_meter_if;
    logic       pin;
    logic       clear;
    logic [6:0] duty;
    logic       valid;

    modport meter (input pin, input clear, output duty, output valid);
    modport user  (output pin, output clear, input duty, input valid);
endinterface

/* File: hdl/hdms_duty_meter.sv */
/*
 * Duty cycle meter: counts high samples of one pin over a window of
 * 2**WIN_BITS clocks and reports the share in steps of 1/128.
 * Assumes the pin is synchronous to CLK.
 */
`timescale 1ns/10ps
`include "hdms_params.svh"
module hdms_duty_meter
#(
    parameter int WIN_BITS = `HDMS_WIN_BITS
)
(
    input  wire logic   CLK,
    input  wire logic   RESET,
    hdms_meter_if.meter m
);
    import hdms_pkg::*;

    typedef struct packed
    {
        logic [WIN_BITS-1:0] cnt;
        logic [WIN_BITS:0]   high;
        logic [6:0]          duty;
        logic                valid;
    } hdms_meter_st_t;

    hdms_meter_st_t q;
    hdms_meter_st_t d;
    logic [WIN_BITS:0] total;

    if (WIN_BITS < 7)
    begin : g_bad_win
        $error("meter window shorter than the output resolution");
    end

    always_comb
    begin
        d = q;
        total = q.high + {{WIN_BITS{1'b0}}, m.pin};
        if (m.clear)
        begin
            d.cnt = '0;
            d.high = '0;
            d.valid = 1'b0;
        end
        else if (&q.cnt)
        begin
            d.cnt = '0;
            d.high = '0;
            d.valid = 1'b1;
            d.duty = total[WIN_BITS] ? 7'h7F : total[WIN_BITS-1 -: 7];
        end
        else
        begin
            d.cnt = q.cnt + 1'b1;
            d.high = total;
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            q <= '0;
        else
            q <= d;
    end

    assign m.duty = q.duty;
    assign m.valid = q.valid;
endmodule

/* File: hdl/hdms_top.sv */
/*
 * Vibration source selector: control, live amplitude and RAM start address
 * registers, mode decode, live drive level and pattern start pulses.
 * Assumes a synchronous register port and pins synchronous to CLK; the
 * stored and RAM pattern players sit outside and report PATTERN_DONE.
 */
// How it works
// - Modes 1-3 follow duty on pins 0-2
// - Mode 4 pin three, mode 5 pin four
// - Mode 6 drives from live amplitude register
// - Pin pulse starts stored pattern, modes 7-11
// - Mode 12 starts on control bit seven
// - Modes 13-17 play RAM on pin pulse, 18 on bit seven
// - Amplitude step is 0.78 percent full scale
// - Amplitude top bit gives drive polarity
// - RAM playback starts at start address register
`timescale 1ns/10ps
`include "hdms_params.svh"
module hdms_top
#(
    parameter int WIN_BITS = `HDMS_WIN_BITS
)
(
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic [4:0] MP_PIN,
    input  wire logic       PATTERN_DONE,
    output logic            DRIVE_EN,
    output logic            DRIVE_NEG,
    output logic      [6:0] DRIVE_LEVEL,
    output logic            STORED_START,
    output logic            RAM_START,
    output logic      [7:0] RAM_ADDR,
    output logic            PLAYING
);
    import hdms_pkg::*;

    // ****************************************
    // State, decode and meter link
    // ****************************************
    hdms_st_t    q;
    hdms_st_t    d;
    hdms_kind_t  kind;
    logic [2:0]  sel_pin;
    logic        active;
    logic        ctrl_wr;
    logic        mode_chg;
    logic        trig_ev;
    logic [4:0]  pin_rise;
    logic        live_src;

    hdms_meter_if mif ();

    // Window must hold at least one count per output step
    if (WIN_BITS < 7)
    begin : g_bad_top_win
        $error("duty meter window too short");
    end

    hdms_duty_meter #(.WIN_BITS(WIN_BITS)) u_meter
    (
        .CLK   (CLK),
        .RESET (RESET),
        .m     (mif.meter)
    );

    // ****************************************
    // Mode decode
    // ****************************************
    always_comb
    begin
        kind = K_IDLE;
        sel_pin = 3'h0;
        if (q.mode >= `HDMS_MODE_PWM0 && q.mode <= `HDMS_MODE_PWM4)
        begin
            kind = K_PWM;
            sel_pin = 3'(q.mode - `HDMS_MODE_PWM0);
        end
        else if (q.mode == `HDMS_MODE_LIVE_REG)
            kind = K_REG;
        else if (q.mode >= `HDMS_MODE_STORED0 && q.mode <= `HDMS_MODE_STORED4)
        begin
            kind = K_STORED_PIN;
            sel_pin = 3'(q.mode - `HDMS_MODE_STORED0);
        end
        else if (q.mode == `HDMS_MODE_STORED_REG)
            kind = K_STORED_REG;
        else if (q.mode >= `HDMS_MODE_RAM_FIRST && q.mode <= `HDMS_MODE_RAM_PIN4)
        begin
            kind = K_RAM_PIN;
            sel_pin = 3'(q.mode - `HDMS_RAM_PIN_BASE);
        end
        else if (q.mode == `HDMS_MODE_RAM_PIN0)
            kind = K_RAM_PIN;
        else if (q.mode == `HDMS_MODE_RAM_REG)
            kind = K_RAM_REG;
    end

    // RAM sources also need the RAM block enabled
    assign active = q.gate && kind != K_IDLE
                    && (q.ram_en || (kind != K_RAM_PIN && kind != K_RAM_REG));
    assign ctrl_wr = REG_WR && REG_ADDR == `HDMS_OFS_CONTROL;
    assign mode_chg = ctrl_wr && (REG_WDATA[`HDMS_MODE_MSB:0] != q.mode || !REG_WDATA[`HDMS_BIT_CLK_GATE]);
    assign pin_rise = MP_PIN & ~q.pins_prev;
    assign live_src = kind == K_PWM || kind == K_REG;

    always_comb
    begin
        trig_ev = 1'b0;
        if (kind == K_STORED_PIN || kind == K_RAM_PIN)
            trig_ev = pin_rise[sel_pin];
        else if (kind == K_STORED_REG || kind == K_RAM_REG)
            trig_ev = ctrl_wr && REG_WDATA[`HDMS_BIT_TRIGGER];
    end

    assign mif.pin = MP_PIN[sel_pin];
    assign mif.clear = kind != K_PWM || !active || mode_chg;

    // ****************************************
    // Registers and sequencing
    // ****************************************
    always_comb
    begin
        d = q;
        d.pins_prev = MP_PIN;
        d.stored_start = 1'b0;
        d.ram_start = 1'b0;
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                `HDMS_OFS_CONTROL:
                begin
                    d.trig = REG_WDATA[`HDMS_BIT_TRIGGER];
                    d.ram_en = REG_WDATA[`HDMS_BIT_RAM_EN];
                    d.gate = REG_WDATA[`HDMS_BIT_CLK_GATE];
                    d.mode = REG_WDATA[`HDMS_MODE_MSB:0];
                end
                `HDMS_OFS_LIVE_AMP: d.live_amp = REG_WDATA;
                `HDMS_OFS_RAM_ADDR: d.ram_addr = REG_WDATA;
                default: ;
            endcase
        end
        d.rdata = `HDMS_RST_REG;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                `HDMS_OFS_CONTROL: d.rdata = {q.trig, q.ram_en, q.gate, q.mode};
                `HDMS_OFS_LIVE_AMP: d.rdata = q.live_amp;
                `HDMS_OFS_RAM_ADDR: d.rdata = q.ram_addr;
                default: d.rdata = `HDMS_RST_REG;
            endcase
        end
        unique case (q.state)
            ST_IDLE:
            begin
                if (active && !mode_chg)
                    d.state = live_src ? ST_LIVE : ST_ARMED;
            end
            ST_LIVE:
            begin
                if (!active || mode_chg)
                    d.state = ST_IDLE;
            end
            ST_ARMED:
            begin
                if (!active || mode_chg)
                    d.state = ST_IDLE;
                else if (trig_ev)
                begin
                    d.state = ST_PLAY;
                    if (kind == K_RAM_PIN || kind == K_RAM_REG)
                    begin
                        d.ram_start = 1'b1;
                        d.play_addr = q.ram_addr;
                    end
                    else
                        d.stored_start = 1'b1;
                end
            end
            ST_PLAY:
            begin
                if (!active || mode_chg)
                    d.state = ST_IDLE;
                else if (PATTERN_DONE)
                    d.state = ST_ARMED;
            end
            default: d.state = ST_IDLE;
        endcase
        d.en = d.state == ST_LIVE || d.state == ST_PLAY;
        d.level = 7'h00;
        d.neg = 1'b0;
        if (d.state == ST_LIVE && kind == K_REG)
        begin
            d.level = q.live_amp[6:0];
            d.neg = q.live_amp[`HDMS_SIGN_BIT];
        end
        else if (d.state == ST_LIVE && mif.valid)
            d.level = mif.duty;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            q <= '{state: ST_IDLE, default: '0};
        else
            q <= d;
    end

    assign REG_RDATA = q.rdata;
    assign DRIVE_EN = q.en;
    assign DRIVE_NEG = q.neg;
    assign DRIVE_LEVEL = q.level;
    assign STORED_START = q.stored_start;
    assign RAM_START = q.ram_start;
    assign RAM_ADDR = q.play_addr;
    assign PLAYING = q.state == ST_PLAY;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence seq_armed_trig;
        q.state == ST_ARMED && active && !mode_chg && trig_ev;
    endsequence

    sequence seq_one_pulse(sig);
        sig ##1 !sig;
    endsequence

    sequence seq_live_hold;
        q.state == ST_LIVE && active && !mode_chg;
    endsequence

    a_idle_no_drive: assert property (q.mode == `HDMS_MODE_IDLE |=> !DRIVE_EN)
        else $error("drive active with mode zero");

    a_pwm_level: assert property (seq_live_hold and kind == K_PWM && mif.valid
                                  |=> DRIVE_EN && DRIVE_LEVEL == $past(mif.duty) && !DRIVE_NEG)
        else $error("live duty level not passed to drive");

    a_pwm_pin_map: assert property (q.mode == 5'h04 || q.mode == 5'h05 |->
                                    kind == K_PWM && sel_pin == 3'(q.mode - 5'h01))
        else $error("duty mode reads wrong pin");

    a_reg_level: assert property (seq_live_hold and kind == K_REG
                                  |=> DRIVE_LEVEL == $past(q.live_amp[6:0]))
        else $error("live register magnitude not driven");

    a_reg_sign: assert property (seq_live_hold and kind == K_REG
                                 |=> DRIVE_EN && DRIVE_NEG == $past(q.live_amp[7]))
        else $error("live register sign not driven");

    a_pin_start: assert property (seq_armed_trig and kind == K_STORED_PIN
                                  |=> seq_one_pulse(STORED_START) and PLAYING)
        else $error("pin pulse did not start stored pattern");

    a_reg_start: assert property (seq_armed_trig and kind == K_STORED_REG
                                  |=> STORED_START && !RAM_START)
        else $error("trigger bit did not start stored pattern");

    a_ram_start: assert property (seq_armed_trig and (kind == K_RAM_PIN || kind == K_RAM_REG)
                                  |=> seq_one_pulse(RAM_START) and RAM_ADDR == $past(q.ram_addr))
        else $error("RAM playback not started at start address");

    a_gate_off: assert property (!q.gate |=> !DRIVE_EN && !STORED_START)
        else $error("drive without clock gate");

    // Source, start, play and duty meter checks
    a_unlisted_idle: assert property (kind == K_IDLE |=> !DRIVE_EN && !PLAYING)
        else $error("drive active with no source selected");

    a_play_no_level: assert property (PLAYING |-> DRIVE_EN && DRIVE_LEVEL == 7'h00 && !DRIVE_NEG)
        else $error("live level present during pattern play");

    a_neg_reg_only: assert property (kind != K_REG |=> !DRIVE_NEG)
        else $error("negative drive outside live register mode");

    a_start_playing: assert property (STORED_START || RAM_START |-> PLAYING)
        else $error("start pulse without play state");

    a_start_armed: assert property (q.state != ST_ARMED |=> !STORED_START && !RAM_START)
        else $error("pattern started while not armed");

    a_done_rearm: assert property (PLAYING && PATTERN_DONE && active && !mode_chg
                                   |=> !PLAYING && !DRIVE_EN)
        else $error("play did not end on pattern done");

    a_meter_restart: assert property (mode_chg |=> !mif.valid)
        else $error("duty meter kept old result over mode change");

    a_duty_wait: assert property (q.state == ST_LIVE && kind == K_PWM && !mif.valid
                                  |=> DRIVE_LEVEL == 7'h00)
        else $error("duty level driven before first window");

    a_ram_addr_hold: assert property (q.state != ST_ARMED |=> $stable(RAM_ADDR))
        else $error("RAM start address changed outside a start");
endmodule

/* File: tb/hdms_host_model.sv */
/*
 * Host side model: PWM source on one chosen pin and a pattern player
 * stand-in that reports end of play. Assumes the block's clock and reset.
 */
`timescale 1ns/10ps
module hdms_host_model
#(
    parameter int PLAY_LEN = 6
)
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [2:0] pwm_pin,
    input  wire logic [7:0] pwm_high,
    input  wire logic       start,
    output logic      [4:0] pwm_out,
    output logic            done
);
    logic [7:0] phase_q;
    logic [3:0] play_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            phase_q <= 8'h00;
            play_q  <= 4'h0;
        end
        else
        begin
            phase_q <= phase_q + 8'h01;
            if (start)
                play_q <= 4'(PLAY_LEN);
            else if (play_q != 4'h0)
                play_q <= play_q - 4'h1;
        end
    end

    // Duty of pwm_high/256 on one pin; a code above 4 leaves all low
    always_comb
    begin
        pwm_out = 5'h00;
        if (pwm_pin < 3'h5)
            pwm_out[pwm_pin] = (phase_q < pwm_high);
    end

    assign done = (play_q == 4'h1);
endmodule

/* File: tb/hdms_top_bench.sv */
/*
 * Bench of the vibration source selector: registers, live modes, pin and
 * register triggered patterns. Assumes package, interface, model compiled.
 */
`timescale 1ns/10ps
module hdms_top_bench;
    logic       clk;
    logic       reset;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] pins;
    logic [4:0] pwm;
    logic [2:0] psel;
    logic [7:0] phigh;
    logic       done;
    logic       en;
    logic       neg;
    logic [6:0] lvl;
    logic       sst;
    logic       rst;
    logic [7:0] raddr;
    logic       play;
    int         error_cnt;
    int         compares;
    int         i;
    int         p;
    logic [7:0] idle_codes [3] = '{8'h20, 8'h33, 8'h3F};

    hdms_top dut
    (
        .CLK(clk),
        .RESET(reset),
        .REG_WR(wr),
        .REG_RD(rd),
        .REG_ADDR(addr),
        .REG_WDATA(wdata),
        .REG_RDATA(rdata),
        .MP_PIN(pins | pwm),
        .PATTERN_DONE(done),
        .DRIVE_EN(en),
        .DRIVE_NEG(neg),
        .DRIVE_LEVEL(lvl),
        .STORED_START(sst),
        .RAM_START(rst),
        .RAM_ADDR(raddr),
        .PLAYING(play)
    );

    hdms_host_model host
    (
        .clk(clk),
        .reset(reset),
        .pwm_pin(psel),
        .pwm_high(phigh),
        .start(sst | rst),
        .pwm_out(pwm),
        .done(done)
    );

    always #5 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, d);
        tick(1);
        chk(rdata, 8'h00);
    endtask

    // Arm a triggered mode, try a wrong pin, then fire and follow the play
    task automatic fire(input logic [4:0] m, input int pn, input logic [7:0] a);
        logic ram;
        int   n;
        ram = (m > 5'h0C);
        wreg(8'h0B, a);
        wreg(8'h09, {1'b0, ram, 1'b1, m});
        tick(4);
        pins <= 5'h01 << ((pn + 1) % 5);
        tick(1);
        pins <= 5'h00;
        tick(3);
        chk(8'(play), 8'h00);
        @(posedge clk);
        if (pn > 4)
        begin
            wr    <= 1'b1;
            addr  <= 8'h09;
            wdata <= {1'b1, ram, 1'b1, m};
        end
        else
            pins <= 5'h01 << pn;
        for (n = 0; n < 6; n++)
        begin
            @(posedge clk);
            wr   <= 1'b0;
            pins <= 5'h00;
            #1;
            if (sst === 1'b1 || rst === 1'b1)
                break;
        end
        chk({6'h00, sst, rst}, ram ? 8'h01 : 8'h02);
        chk({play, lvl}, 8'h80);
        chk(8'(en), 8'h01);
        if (ram)
            chk(raddr, a);
        tick(1);
        chk({6'h00, sst, rst}, 8'h00);
        for (n = 0; n < 20 && done !== 1'b1; n++)
            tick(1);
        tick(1);
        chk({6'h00, play, en}, 8'h00);
    endtask

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial
    begin
        clk       = 1'b0;
        reset     = 1'b1;
        wr        = 1'b0;
        rd        = 1'b0;
        addr      = 8'h00;
        wdata     = 8'h00;
        pins      = 5'h00;
        psel      = 3'h7;
        phigh     = 8'h00;
        error_cnt = 0;
        compares  = 0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        tick(1);
        chk({en, neg, sst, rst, play, 3'h0}, 8'h00);
        chk({1'b0, lvl}, 8'h00);
        chk(raddr, 8'h00);
        rreg(8'h09, 8'h00);
        rreg(8'h0A, 8'h00);
        rreg(8'h0B, 8'h00);
        wreg(8'h0B, 8'hA5);
        wreg(8'h0C, 8'hFF);
        wreg(8'h09, 8'hC0);
        rreg(8'h0B, 8'hA5);
        rreg(8'h0C, 8'h00);
        rreg(8'h09, 8'hC0);
        $display("Test registers done");
        wreg(8'h0A, 8'h05);
        wreg(8'h09, 8'h26);
        tick(2);
        chk(8'(en), 8'h01);
        chk({neg, lvl}, 8'h05);
        wreg(8'h0A, 8'hFA);
        tick(2);
        chk({neg, lvl}, 8'hFA);
        $display("Test live register done");
        for (i = 0; i < 3; i++)
        begin
            wreg(8'h09, idle_codes[i]);
            tick(3);
            pins <= 5'h1F;
            tick(1);
            pins <= 5'h00;
            tick(3);
            chk({en, play, sst, rst, 4'h0}, 8'h00);
        end
        $display("Test idle codes done");
        for (i = 0; i < 5; i++)
        begin
            psel  <= 3'(i);
            phigh <= 8'h30 + 8'(i * 45);
            wreg(8'h09, 8'h21 + 8'(i));
            tick(600);
            chk({1'b0, lvl}, (8'h30 + 8'(i * 45)) >> 1);
            chk(8'(en), 8'h01);
            wreg(8'h09, 8'h20);
            tick(3);
            chk(8'(en), 8'h00);
        end
        psel <= 3'h7;
        $display("Test duty modes done");
        for (i = 0; i < 12; i++)
        begin
            p = (i < 5) ? i : (i == 5 || i == 11) ? 5 : (i == 10) ? 0 : i - 5;
            fire(5'h07 + 5'(i), p, 8'h10 + 8'(i));
        end
        $display("Test triggered modes done");
        wreg(8'h09, 8'h20);
        wreg(8'h09, 8'h00);
        tick(2);
        finish_test();
    end
endmodule
